/* hw/aatac_pkg.sv */
/*
 * package for the address table access control block: register offsets,
 * field positions, reset values, write masks, fsm states and the state struct.
 * assumes a byte-addressed register port with four byte enables per word.
 */
package aatac_pkg;
    // register byte offsets
    localparam logic [15:0] IDX_HI_ADDR = 16'h0410;
    localparam logic [15:0] IDX_LO_ADDR = 16'h0414;
    localparam logic [15:0] LK_CTRL_ADDR = 16'h0418;
    localparam logic [15:0] TB_CTRL_ADDR = 16'h041c;
    localparam logic [15:0] ENTRY_BASE_ADDR = 16'h0420;
    localparam logic [15:0] ENTRY_LAST_ADDR = 16'h042c;
    // byte lane of 0x042f inside the last entry word
    localparam int ENTRY_LAST_LANE = 3;
    // field positions
    localparam int FID_LSB = 16;
    localparam int FID_MSB = 22;
    localparam int KEY_HI_MSB = 15;
    localparam int DIRECT_MSB = 11;
    localparam int GO_BIT = 7;
    localparam int FOUND_BIT = 6;
    localparam int READY_BIT = 5;
    localparam int DIRECT_BIT = 2;
    localparam int CNT_LSB = 16;
    localparam int TB_IDX_LSB = 16;
    localparam int TB_SEL_BIT = 1;
    localparam int TB_DIR_BIT = 0;
    localparam int ENTRY_VALID_BIT = 31;
    // writable bits per register
    localparam logic [31:0] IDX_HI_MASK = 32'h807f_ffff;
    localparam logic [31:0] LK_CTRL_MASK = 32'h0000_001f;
    localparam logic [31:0] TB_CTRL_MASK = 32'h003f_007f;
    // reset values
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [13:0] CNT_RESET = 14'h0000;
    // table sizes
    localparam int LK_DEPTH = 4096;
    localparam int ST_DEPTH = 16;
    localparam int MC_DEPTH = 64;
    localparam logic [11:0] LK_LAST = 12'hfff;
    // lookup actions
    localparam logic [1:0] ACT_NOP = 2'h0;
    localparam logic [1:0] ACT_WRITE = 2'h1;
    localparam logic [1:0] ACT_READ = 2'h2;
    localparam logic [1:0] ACT_SEARCH = 2'h3;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_LOOKUP = 5'b00010,
        S_SCAN = 5'b00100,
        S_HOLD = 5'b01000,
        S_TABLE = 5'b10000
    } aatac_fsm_t;

    // register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } aatac_req_t;

    typedef struct packed {
        aatac_fsm_t fsm;
        logic [31:0] idx_hi;
        logic [31:0] idx_lo;
        logic [4:0] lk_cfg;
        logic lk_go;
        logic found;
        logic search_end;
        logic [13:0] valid_count;
        logic [13:0] cnt;
        logic [11:0] scan;
        logic [5:0] tb_idx;
        logic [6:0] tb_cfg;
        logic tb_go;
        logic [3:0][31:0] entry;
        logic [31:0] rdata;
        logic rvalid;
    } aatac_state_t;
endpackage

/* hw/aatac_ctrl.sv */
/*
 * access control for the address lookup, static address and reserved
 * multicast tables, with the tables themselves and the entry data registers.
 * assumes single-cycle register requests on clk, read data one cycle later.
 */
// Overview of operation
// - the filter group id in index-high bits 22:16 enters the lookup hash.
// - index-high bits 15:0 supply key bits 47:32 to the lookup hash.
// - index-low holds key bits 31:0 and its bits 11:0 are the direct index.
// - after a search the valid entry count shows in control bits 29:16.
// - writing 1 to control bit 7 starts the lookup action; it clears when done.
// - bit 6 sets when a found entry waits and clears on a read of byte 0x042f.
// - bit 5 reads as bit 6 or a search that has run to its end.
// - control bit 2 high indexes directly, low uses the hash.
// - action 00 nop, 01 write, 10 read, 11 search valid entries.
// - the table index uses bits 21:16 for multicast and 19:16 for static.
// - writing 1 to bit 7 of the table control starts an access; it clears when done.
// - table control bit 1 picks multicast when high and static when low.
// - table control bit 0 reads when high and writes when low.
// - static accesses use all four entry words, multicast only the second.
// - lookup reads, writes and search hits move data through the entry words.
`timescale 1ns/1ps
module aatac_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire aatac_pkg::aatac_req_t req,
    output logic [31:0] rdata,
    output logic rvalid
);
    aatac_pkg::aatac_state_t st;
    aatac_pkg::aatac_state_t next_st;

    // tables and the lookup valid map
    logic [127:0] lk_mem [aatac_pkg::LK_DEPTH];
    logic [127:0] st_mem [aatac_pkg::ST_DEPTH];
    logic [31:0] mc_mem [aatac_pkg::MC_DEPTH];
    logic [aatac_pkg::LK_DEPTH-1:0] lk_valid;

    logic lk_we;
    logic st_we;
    logic mc_we;
    logic [11:0] lk_addr;
    logic [127:0] lk_word;
    logic [11:0] hash_idx;
    logic rd_last;

    // folds filter group id and 48-bit key into a 12-bit index
    function automatic logic [11:0] fold(input logic [6:0] filter_group_id, input logic [47:0] key);
        logic [59:0] v;
        v = {5'h00, filter_group_id, key};
        return v[11:0] ^ v[23:12] ^ v[35:24] ^ v[47:36] ^ v[59:48];
    endfunction

    // merges written bytes into a register under a writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
        return (old & ~m) | (wd & m);
    endfunction

    // lookup address from hash or direct index
    assign hash_idx = fold(st.idx_hi[aatac_pkg::FID_MSB:aatac_pkg::FID_LSB],
                           {st.idx_hi[aatac_pkg::KEY_HI_MSB:0], st.idx_lo});
    assign lk_addr = st.lk_cfg[aatac_pkg::DIRECT_BIT] ?
                     st.idx_lo[aatac_pkg::DIRECT_MSB:0] : hash_idx;
    assign lk_word = lk_mem[lk_addr];
    assign rd_last = req.rd && req.addr == aatac_pkg::ENTRY_LAST_ADDR
                     && req.be[aatac_pkg::ENTRY_LAST_LANE];

    // next state: register writes, reads, then the access engine
    always_comb begin
        logic busy;
        logic [31:0] w;
        next_st = st;
        busy = st.lk_go | st.tb_go;
        w = 32'h0000_0000;
        lk_we = 1'b0;
        st_we = 1'b0;
        mc_we = 1'b0;
        next_st.rvalid = 1'b0;
        if (req.wr) begin
            case (req.addr)
                aatac_pkg::IDX_HI_ADDR: begin
                    next_st.idx_hi = merge(st.idx_hi, req.wdata, req.be, aatac_pkg::IDX_HI_MASK);
                end
                aatac_pkg::IDX_LO_ADDR: begin
                    next_st.idx_lo = merge(st.idx_lo, req.wdata, req.be, '1);
                end
                aatac_pkg::LK_CTRL_ADDR: begin
                    if (!busy) begin
                        w = merge({27'h0, st.lk_cfg}, req.wdata, req.be, aatac_pkg::LK_CTRL_MASK);
                        next_st.lk_cfg = w[4:0];
                        if (req.be[0] && req.wdata[aatac_pkg::GO_BIT]) begin
                            next_st.lk_go = 1'b1;
                            next_st.found = 1'b0;
                            next_st.search_end = 1'b0;
                            next_st.cnt = aatac_pkg::CNT_RESET;
                            next_st.scan = 12'h000;
                            next_st.fsm = (w[1:0] == aatac_pkg::ACT_SEARCH) ?
                                          aatac_pkg::S_SCAN : aatac_pkg::S_LOOKUP;
                        end
                    end
                end
                aatac_pkg::TB_CTRL_ADDR: begin
                    if (!busy) begin
                        w = merge({10'h0, st.tb_idx, 9'h0, st.tb_cfg}, req.wdata, req.be,
                                  aatac_pkg::TB_CTRL_MASK);
                        next_st.tb_idx = w[21:16];
                        next_st.tb_cfg = w[6:0];
                        if (req.be[0] && req.wdata[aatac_pkg::GO_BIT]) begin
                            next_st.tb_go = 1'b1;
                            next_st.fsm = aatac_pkg::S_TABLE;
                        end
                    end
                end
                default: begin
                    if (req.addr[15:4] == aatac_pkg::ENTRY_BASE_ADDR[15:4]
                        && req.addr[1:0] == 2'h0) begin
                        next_st.entry[req.addr[3:2]] = merge(st.entry[req.addr[3:2]],
                                                             req.wdata, req.be, '1);
                    end
                end
            endcase
        end
        // registered read data, reserved bits as zero
        if (req.rd) begin
            next_st.rvalid = 1'b1;
            case (req.addr)
                aatac_pkg::IDX_HI_ADDR: next_st.rdata = st.idx_hi;
                aatac_pkg::IDX_LO_ADDR: next_st.rdata = st.idx_lo;
                aatac_pkg::LK_CTRL_ADDR: begin
                    next_st.rdata = {2'h0, st.valid_count, 8'h00, st.lk_go, st.found,
                                     st.found | st.search_end, st.lk_cfg};
                end
                aatac_pkg::TB_CTRL_ADDR: begin
                    next_st.rdata = {10'h000, st.tb_idx, 8'h00, st.tb_go, st.tb_cfg};
                end
                default: begin
                    if (req.addr[15:4] == aatac_pkg::ENTRY_BASE_ADDR[15:4]
                        && req.addr[1:0] == 2'h0) begin
                        next_st.rdata = st.entry[req.addr[3:2]];
                    end else begin
                        next_st.rdata = 32'h0000_0000;
                    end
                end
            endcase
        end
        // reading byte 0x042f releases the waiting entry
        if (rd_last) begin
            next_st.found = 1'b0;
        end
        // access engine; hardware loads win over a same-cycle software write
        case (st.fsm)
            aatac_pkg::S_IDLE: begin
            end
            aatac_pkg::S_LOOKUP: begin
                if (st.lk_cfg[1:0] == aatac_pkg::ACT_WRITE) begin
                    lk_we = 1'b1;
                end else if (st.lk_cfg[1:0] == aatac_pkg::ACT_READ) begin
                    next_st.entry = {lk_word[31:0], lk_word[63:32], lk_word[95:64],
                                     lk_word[127:96]};
                end
                next_st.lk_go = 1'b0;
                next_st.fsm = aatac_pkg::S_IDLE;
            end
            aatac_pkg::S_SCAN: begin
                if (lk_valid[st.scan]) begin
                    w = 32'h0000_0000;
                    next_st.entry = {lk_mem[st.scan][31:0], lk_mem[st.scan][63:32],
                                     lk_mem[st.scan][95:64], lk_mem[st.scan][127:96]};
                    next_st.found = 1'b1;
                    next_st.cnt = st.cnt + 14'h0001;
                    next_st.fsm = aatac_pkg::S_HOLD;
                end else if (st.scan == aatac_pkg::LK_LAST) begin
                    next_st.valid_count = st.cnt;
                    next_st.search_end = 1'b1;
                    next_st.lk_go = 1'b0;
                    next_st.fsm = aatac_pkg::S_IDLE;
                end else begin
                    next_st.scan = st.scan + 12'h001;
                end
            end
            aatac_pkg::S_HOLD: begin
                if (!st.found) begin
                    if (st.scan == aatac_pkg::LK_LAST) begin
                        next_st.valid_count = st.cnt;
                        next_st.search_end = 1'b1;
                        next_st.lk_go = 1'b0;
                        next_st.fsm = aatac_pkg::S_IDLE;
                    end else begin
                        next_st.scan = st.scan + 12'h001;
                        next_st.fsm = aatac_pkg::S_SCAN;
                    end
                end
            end
            aatac_pkg::S_TABLE: begin
                if (st.tb_cfg[aatac_pkg::TB_SEL_BIT]) begin
                    if (st.tb_cfg[aatac_pkg::TB_DIR_BIT]) begin
                        next_st.entry[1] = mc_mem[st.tb_idx];
                    end else begin
                        mc_we = 1'b1;
                    end
                end else if (st.tb_cfg[aatac_pkg::TB_DIR_BIT]) begin
                    next_st.entry = st_mem[st.tb_idx[3:0]];
                end else begin
                    st_we = 1'b1;
                end
                next_st.tb_go = 1'b0;
                next_st.fsm = aatac_pkg::S_IDLE;
            end
            default: next_st.fsm = aatac_pkg::S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.fsm <= aatac_pkg::S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // table writes; lookup valid map follows the entry valid bit
    always_ff @(posedge clk) begin
        if (rst) begin
            lk_valid <= '0;
        end else if (lk_we) begin
            lk_valid[lk_addr] <= st.entry[0][aatac_pkg::ENTRY_VALID_BIT];
        end
        if (lk_we) begin
            lk_mem[lk_addr] <= {st.entry[0], st.entry[1], st.entry[2], st.entry[3]};
        end
        if (st_we) begin
            st_mem[st.tb_idx[3:0]] <= st.entry;
        end
        if (mc_we) begin
            mc_mem[st.tb_idx] <= st.entry[1];
        end
    end

    assign rdata = st.rdata;
    assign rvalid = st.rvalid;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // go bits, search count and index paths
    chk_lookup_go_clear: assert property (
        st.fsm == aatac_pkg::S_LOOKUP |=> !st.lk_go && st.fsm == aatac_pkg::S_IDLE)
        else $error("lookup go bit not cleared after action");
    chk_search_count: assert property (
        st.fsm == aatac_pkg::S_SCAN && !lk_valid[st.scan] && st.scan == aatac_pkg::LK_LAST
        |=> st.valid_count == $past(st.cnt) && !st.lk_go)
        else $error("valid count not reported at search end");
    chk_found_read_clear: assert property (
        st.fsm == aatac_pkg::S_HOLD && st.found && rd_last
        |=> !st.found ##1 st.fsm != aatac_pkg::S_HOLD)
        else $error("found flag not cleared by entry read");
    chk_ready_combined: assert property (
        req.rd && req.addr == aatac_pkg::LK_CTRL_ADDR
        |=> rdata[aatac_pkg::READY_BIT] == ($past(st.found) | $past(st.search_end)))
        else $error("ready bit does not combine found and end");
    chk_direct_index: assert property (
        lk_we && st.lk_cfg[aatac_pkg::DIRECT_BIT] |-> lk_addr == st.idx_lo[11:0])
        else $error("direct index not taken from key low bits");
    chk_hash_index: assert property (
        lk_we && !st.lk_cfg[aatac_pkg::DIRECT_BIT]
        |-> lk_addr == fold(st.idx_hi[22:16], {st.idx_hi[15:0], st.idx_lo}))
        else $error("hashed index wrong");
    chk_search_start: assert property (
        st.fsm == aatac_pkg::S_IDLE && req.wr && req.addr == aatac_pkg::LK_CTRL_ADDR
        && req.be[0] && req.wdata[7] && req.wdata[1:0] == aatac_pkg::ACT_SEARCH
        |=> st.fsm == aatac_pkg::S_SCAN && st.lk_go)
        else $error("search action did not start a scan");
    chk_table_go_clear: assert property (
        st.fsm == aatac_pkg::S_TABLE |=> !st.tb_go)
        else $error("table go bit not cleared");
    chk_mcast_read: assert property (
        st.fsm == aatac_pkg::S_TABLE && st.tb_cfg[1:0] == 2'h3
        |=> st.entry[1] == $past(mc_mem[st.tb_idx]) && st.entry[0] == $past(st.entry[0]))
        else $error("multicast read not placed in second entry word");
    chk_lookup_read: assert property (
        st.fsm == aatac_pkg::S_LOOKUP && st.lk_cfg[1:0] == aatac_pkg::ACT_READ
        |=> st.entry[0] == $past(lk_word[127:96]) && st.entry[3] == $past(lk_word[31:0]))
        else $error("lookup read not placed in entry words");

    // control writes are dropped while an engine runs
    chk_busy_lk_keep: assert property (
        (st.lk_go || st.tb_go) && req.wr && req.addr == aatac_pkg::LK_CTRL_ADDR
        |=> st.lk_cfg == $past(st.lk_cfg))
        else $error("lookup control changed while busy");
    chk_busy_tb_keep: assert property (
        (st.lk_go || st.tb_go) && req.wr && req.addr == aatac_pkg::TB_CTRL_ADDR
        |=> st.tb_cfg == $past(st.tb_cfg) && st.tb_idx == $past(st.tb_idx))
        else $error("table control changed while busy");

    // search pauses on a hit and reports its end
    chk_hit_pause: assert property (
        st.fsm == aatac_pkg::S_SCAN && lk_valid[st.scan]
        |=> st.found && st.fsm == aatac_pkg::S_HOLD)
        else $error("search did not pause on a valid entry");
    chk_hold_end: assert property (
        st.fsm == aatac_pkg::S_HOLD && !st.found && st.scan == aatac_pkg::LK_LAST
        |=> st.search_end && !st.lk_go && st.valid_count == $past(st.cnt))
        else $error("search end not reported after last entry");
    chk_end_idle: assert property (
        st.search_end |-> !st.lk_go && !st.found)
        else $error("search end flag set while a search runs");

    // lookup action decode
    chk_write_action: assert property (
        st.fsm == aatac_pkg::S_LOOKUP && st.lk_cfg[1:0] == aatac_pkg::ACT_WRITE |-> lk_we)
        else $error("write action did not write the lookup table");
    chk_nop_action: assert property (
        st.fsm == aatac_pkg::S_LOOKUP && st.lk_cfg[1:0] == aatac_pkg::ACT_NOP
        |-> !lk_we ##1 st.entry == $past(st.entry))
        else $error("no-operation action touched the table");

    // static and multicast table accesses
    chk_table_start: assert property (
        st.fsm == aatac_pkg::S_IDLE && req.wr && req.addr == aatac_pkg::TB_CTRL_ADDR
        && req.be[0] && req.wdata[7] |=> st.fsm == aatac_pkg::S_TABLE && st.tb_go)
        else $error("table access did not start");
    chk_static_read: assert property (
        st.fsm == aatac_pkg::S_TABLE && st.tb_cfg[1:0] == 2'h1
        |=> st.entry == $past(st_mem[st.tb_idx[3:0]]))
        else $error("static read not placed in all entry words");
    chk_table_write: assert property (
        st.fsm == aatac_pkg::S_TABLE
        |-> (st_we == (st.tb_cfg[1:0] == 2'h0)) && (mc_we == (st.tb_cfg[1:0] == 2'h2)))
        else $error("table write strobe does not follow select and direction");

    // every read is answered in the next cycle
    chk_read_answer: assert property (
        req.rd |=> rvalid)
        else $error("read not answered in the next cycle");

    cov_search_hit: cover property (st.fsm == aatac_pkg::S_SCAN ##1 st.found);
    cov_search_end: cover property (st.fsm == aatac_pkg::S_SCAN ##1 !st.lk_go);
    cov_static_read: cover property (st.fsm == aatac_pkg::S_TABLE && st.tb_cfg[1:0] == 2'h1);
    cov_lookup_write: cover property (lk_we);
endmodule // aatac_ctrl

/* verification/tb_top.sv */
/*
 * self-checking bench for the address table access control block.
 * assumes the word-wide register port of aatac_ctrl, one clock, sync reset.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin errors++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end
module tb_top;
    logic clk;
    logic rst;
    aatac_pkg::aatac_req_t req;
    logic [31:0] rdata;
    logic rvalid;
    int errors = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] rd_val;

    aatac_ctrl i_aatac_ctrl (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .rvalid(rvalid));

    // clock at 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            $display("mismatch at %0t: run did not finish", $time);
            final_report();
        end
    end

    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // one write pulse, driven on the falling edge
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hf, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    // one read pulse, answer taken one cycle later
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'hf, wdata: 32'h0000_0000};
        @(negedge clk);
        req.rd = 1'b0;
        `CHK(rvalid, 1'b1)
        d = rdata;
    endtask

    // poll a control word until its go bit drops
    task automatic wait_done(input logic [15:0] a);
        int n;
        n = 0;
        rd(a, rd_val);
        while (rd_val[aatac_pkg::GO_BIT] !== 1'b0 && n < 5000) begin
            rd(a, rd_val);
            n++;
        end
        `CHK(rd_val[aatac_pkg::GO_BIT], 1'b0)
    endtask

    task automatic set_entries(input logic [3:0][31:0] e);
        for (int i = 0; i < 4; i++) begin
            wr(aatac_pkg::ENTRY_BASE_ADDR + 16'(4 * i), e[i]);
        end
    endtask

    task automatic chk_entries(input logic [3:0][31:0] e);
        for (int i = 0; i < 4; i++) begin
            rd(aatac_pkg::ENTRY_BASE_ADDR + 16'(4 * i), rd_val);
            `CHK(rd_val, e[i])
        end
    endtask

    // reset values, writable masks, unmapped address
    task automatic t_regs();
        rd(aatac_pkg::IDX_HI_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        wr(aatac_pkg::IDX_HI_ADDR, 32'hffff_ffff);
        rd(aatac_pkg::IDX_HI_ADDR, rd_val);
        `CHK(rd_val, 32'h807f_ffff)
        wr(aatac_pkg::IDX_LO_ADDR, 32'hffff_ffff);
        rd(aatac_pkg::IDX_LO_ADDR, rd_val);
        `CHK(rd_val, 32'hffff_ffff)
        wr(aatac_pkg::TB_CTRL_ADDR, 32'hffff_ff7f);
        rd(aatac_pkg::TB_CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h003f_007f)
        wr(aatac_pkg::TB_CTRL_ADDR, 32'h0000_0000);
        rd(16'h0500, rd_val);
        `CHK(rd_val, 32'h0000_0000)
    endtask

    // direct writes at index 5 and the last index, then read back index 5
    task automatic t_direct();
        wr(aatac_pkg::IDX_LO_ADDR, 32'h0000_0005);
        set_entries({32'h0000_dd05, 32'h0000_cc05, 32'h0000_bb05, 32'h8000_aa05});
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0085);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        wr(aatac_pkg::IDX_LO_ADDR, 32'h0000_0fff);
        set_entries({32'h0000_ddff, 32'h0000_ccff, 32'h0000_bbff, 32'h8000_aaff});
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0085);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        set_entries('0);
        // upper key bits must not disturb the direct index
        wr(aatac_pkg::IDX_LO_ADDR, 32'habcd_e005);
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0086);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        chk_entries({32'h0000_dd05, 32'h0000_cc05, 32'h0000_bb05, 32'h8000_aa05});
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0080);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
    endtask

    // search over the two valid entries, with a refused write while paused
    task automatic t_search();
        logic [31:0] hit [2];
        int n;
        hit = '{32'h8000_aa05, 32'h8000_aaff};
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0083);
        rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
        `CHK(rd_val[7:5], 3'b100)
        for (int k = 0; k < 2; k++) begin
            n = 0;
            rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
            while (rd_val[aatac_pkg::READY_BIT] !== 1'b1 && n < 3000) begin
                rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
                n++;
            end
            `CHK(rd_val[7:5], 3'b111)
            wr(aatac_pkg::TB_CTRL_ADDR, 32'h0001_0081);
            wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0081);
            rd(aatac_pkg::TB_CTRL_ADDR, rd_val);
            `CHK(rd_val, 32'h0000_0000)
            rd(aatac_pkg::ENTRY_BASE_ADDR, rd_val);
            `CHK(rd_val, hit[k])
            rd(aatac_pkg::ENTRY_LAST_ADDR, rd_val);
            rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
            `CHK(rd_val[aatac_pkg::FOUND_BIT], 1'b0)
        end
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        `CHK(rd_val, 32'h0002_0023)
    endtask

    // hashed write and read with filter group id and full key
    task automatic t_hash();
        wr(aatac_pkg::IDX_HI_ADDR, 32'h0012_1234);
        wr(aatac_pkg::IDX_LO_ADDR, 32'h5678_9abc);
        set_entries({32'h0000_4444, 32'h0000_3333, 32'h0000_2222, 32'h0000_1111});
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0081);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        set_entries('0);
        wr(aatac_pkg::LK_CTRL_ADDR, 32'h0000_0082);
        wait_done(aatac_pkg::LK_CTRL_ADDR);
        `CHK(rd_val[7:5], 3'b000)
        chk_entries({32'h0000_4444, 32'h0000_3333, 32'h0000_2222, 32'h0000_1111});
    endtask

    // static table aliasing on four index bits, multicast on the second word
    task automatic t_tables();
        set_entries({32'h5555_0004, 32'h5555_0003, 32'h5555_0002, 32'h5555_0001});
        wr(aatac_pkg::TB_CTRL_ADDR, 32'h0013_0080);
        wait_done(aatac_pkg::TB_CTRL_ADDR);
        set_entries({32'h0000_0000, 32'h0000_0000, 32'h6666_0002, 32'h0000_0000});
        wr(aatac_pkg::TB_CTRL_ADDR, 32'h0023_0082);
        wait_done(aatac_pkg::TB_CTRL_ADDR);
        set_entries('0);
        wr(aatac_pkg::TB_CTRL_ADDR, 32'h0003_0081);
        wait_done(aatac_pkg::TB_CTRL_ADDR);
        `CHK(rd_val, 32'h0003_0001)
        chk_entries({32'h5555_0004, 32'h5555_0003, 32'h5555_0002, 32'h5555_0001});
        set_entries({32'h0000_0007, 32'h0000_0007, 32'h0000_0000, 32'h0000_0007});
        wr(aatac_pkg::TB_CTRL_ADDR, 32'h0023_0083);
        wait_done(aatac_pkg::TB_CTRL_ADDR);
        chk_entries({32'h0000_0007, 32'h0000_0007, 32'h6666_0002, 32'h0000_0007});
    endtask

    // mid-run reset returns index-low and both control registers to zero
    task automatic t_reset();
        wr(aatac_pkg::IDX_LO_ADDR, 32'h1234_5678);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(aatac_pkg::IDX_LO_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        rd(aatac_pkg::TB_CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
        rd(aatac_pkg::LK_CTRL_ADDR, rd_val);
        `CHK(rd_val, 32'h0000_0000)
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        req = '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, be: 4'h0, wdata: 32'h0000_0000};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        t_regs();
        t_direct();
        t_search();
        t_hash();
        t_tables();
        t_reset();
        final_report();
    end
endmodule // tb_top
